// *** sim/acd_host_model.sv ***
// Purpose: host side of the addressed level link, sends and hears words
// Assumes: one bit lasts BIT clocks; released line is biased high
// Notes:   receiver looks for a start bit only while the slave drives the line
`timescale 1ns/1ps
`default_nettype none
module acd_host_model #(
  parameter int unsigned BIT = 8
) (
  input  wire logic       clk,
  output logic            rxd,
  input  wire logic       txd,
  input  wire logic       line_oe,
  output logic            rx_stb,
  output logic [7:0]      rx_byte,
  output logic            rx_par_ok,
  output logic            rx_stop
);
  logic [7:0] sh;

  initial begin
    rxd = 1'b1;
    rx_stb = 1'b0;
    rx_byte = 8'h00;
    rx_par_ok = 1'b0;
    rx_stop = 1'b0;
  end

  task automatic send_word(input logic [7:0] d, input logic bad_par);
    logic [10:0] f;
    f = {1'b1, ^d ^ bad_par, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rxd = f[i];
      repeat (BIT) @(posedge clk);
      #2;
    end
    rxd = 1'b1;
  endtask

  // slave word captured for the monitor's byte check
  initial begin
    forever begin
      @(posedge clk);
      #1;
      if (line_oe === 1'b1 && txd === 1'b0) begin
        repeat (BIT / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
          repeat (BIT) @(posedge clk);
          #1;
          sh[i] = txd;
        end
        repeat (BIT) @(posedge clk);
        #1;
        rx_par_ok = (txd === ^sh);
        repeat (BIT) @(posedge clk);
        #1;
        rx_stop = txd;
        rx_byte = sh;
        rx_stb = 1'b1;
        @(posedge clk);
        #1;
        rx_stb = 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// *** sim/testbench.sv ***
// Purpose: self-checking bench for the address/command decoder
// Assumes: BIT_CYC=8, CMD_WAIT_CYC=400 to keep the run short
// Notes:   expected line bytes queued by the driver, popped by a monitor
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int unsigned BIT  = 8;
  localparam int unsigned WAIT = 400;
  localparam int unsigned WORD = BIT * 11;
  logic       clk, rst_n, rxd, txd, line_oe, wake, meas_start;
  logic       res_valid, res_ready, res_field_end, res_last;
  logic       rx_stb, rx_par_ok, rx_stop, saw_stall;
  logic [7:0] local_addr, cmd_buf, rx_byte, my_addr, old_cmd, exp_b;
  logic [6:0] res_char;
  logic [7:0] exp_q[$];
  logic [7:0] bad_tab[5];
  int         error_cnt, cmp_count;

  acd_decoder #(.BIT_CYC(BIT), .CMD_WAIT_CYC(WAIT)) u_acd_decoder (
    .clk(clk), .rst_n(rst_n), .rxd(rxd), .txd(txd), .line_oe(line_oe),
    .local_addr(local_addr), .wake(wake), .cmd_buf(cmd_buf),
    .meas_start(meas_start), .res_valid(res_valid), .res_ready(res_ready),
    .res_char(res_char), .res_field_end(res_field_end),
    .res_last(res_last));

  acd_host_model #(.BIT(BIT)) host (
    .clk(clk), .rxd(rxd), .txd(txd), .line_oe(line_oe), .rx_stb(rx_stb),
    .rx_byte(rx_byte), .rx_par_ok(rx_par_ok), .rx_stop(rx_stop));

  always #25 clk = ~clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report;
    $display("compares=%0d mismatches=%0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic timeout;
    error_cnt++;
    $display("[FAIL] t=%0t seen=%h exp=%h wait expired", $time, 0, 1);
    final_report;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  // monitor: every slave word must match the oldest note
  always @(posedge clk) begin
    if (res_valid === 1'b1 && res_ready === 1'b0) begin
      saw_stall <= 1'b1;
    end
    if (rx_stb === 1'b1) begin
      if (exp_q.size() == 0) begin
        check({24'h0, rx_byte}, 32'h100);
      end else begin
        exp_b = exp_q.pop_front();
        check(rx_byte, exp_b);
        // address echo is the one byte allowed its top bit
        if (!exp_b[7]) check(rx_byte[7], 1'b0);
        check({rx_par_ok, rx_stop}, 2'b11);
      end
    end
  end

  task automatic push_char(input logic [6:0] ch, input logic fe,
                           input logic last);
    res_valid = 1'b1;
    res_char = ch;
    res_field_end = fe;
    res_last = last;
    for (int k = 0; k < 3000 && res_ready !== 1'b1; k++) step(1);
    if (res_ready !== 1'b1) timeout;
    step(1);
  endtask

  // full interrogation; gap in clocks between address and command
  task automatic full_xact(input logic [7:0] c, input int n, input int gap);
    logic [6:0] ch;
    exp_q.push_back(my_addr);
    exp_q.push_back(c);
    host.send_word(my_addr, 1'b0);
    check(wake, 1'b1);
    step(gap);
    host.send_word(c, 1'b0);
    step(2);
    check(cmd_buf, c);
    for (int k = 0; k < 3000 && meas_start !== 1'b1; k++) step(1);
    if (meas_start !== 1'b1) timeout;
    exp_q.push_back(8'h02);
    for (int i = 0; i < n; i++) begin
      ch = 7'($urandom);
      exp_q.push_back({1'b0, ch});
      exp_q.push_back(i == n - 1 ? 8'h03 : (i % 2 ? 8'h3a : ch));
      if (i % 2 == 0 && i != n - 1) void'(exp_q.pop_back());
      push_char(ch, i % 2 == 1, i == n - 1);
    end
    res_valid = 1'b0;
    for (int k = 0; k < 5000 && line_oe !== 1'b0; k++) step(1);
    if (line_oe !== 1'b0) timeout;
    step(BIT);
    check(exp_q.size(), 0);
    check({wake, line_oe, txd}, 3'b001);
    // quiet time before the next poll
    step(200);
  endtask

  // interrogation that must draw no answer and leave the command
  task automatic no_answer(input logic [7:0] a, input logic ba,
                           input logic bc, input int gap);
    old_cmd = cmd_buf;
    host.send_word(a, ba);
    step(gap);
    host.send_word(8'($urandom) & 8'h7f, bc);
    step(3 * WORD);
    check(cmd_buf, old_cmd);
  endtask

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    res_valid = 1'b0;
    res_char = 7'h00;
    res_field_end = 1'b0;
    res_last = 1'b0;
    error_cnt = 0;
    cmp_count = 0;
    saw_stall = 1'b0;
    void'($urandom(32'h50ea));
    my_addr = 8'(32'hc0 + $urandom % 62);
    local_addr = my_addr;
    step(1);
    check({txd, line_oe, wake, cmd_buf, res_ready}, 12'h801);
    step(1);
    rst_n = 1'b1;
    step(1);
    full_xact(8'h7f, 5, 0);
    check(saw_stall, 1'b1);
    $display("test normal done");
    full_xact(8'h00, 1, 0);
    full_xact(8'($urandom) & 8'h7f, 3, WAIT - WORD - 20);
    $display("test boundaries done");
    no_answer(my_addr, 1'b0, 1'b1, 0);
    check(wake, 1'b0);
    no_answer(my_addr, 1'b1, 1'b0, 0);
    $display("test parity done");
    bad_tab = '{8'h80, 8'hbf, 8'hfe, 8'hff, my_addr ^ 8'h01};
    foreach (bad_tab[i]) begin
      no_answer(bad_tab[i], 1'b0, 1'b0, 0);
      check(wake, 1'b0);
    end
    local_addr = 8'hfe;
    no_answer(8'hfe, 1'b0, 1'b0, 0);
    check(wake, 1'b0);
    local_addr = my_addr;
    old_cmd = cmd_buf;
    host.send_word(8'h15, 1'b0);
    step(2 * WORD);
    check(cmd_buf, old_cmd);
    $display("test addresses done");
    no_answer(my_addr, 1'b0, 1'b0, WAIT);
    // lone address leaves the decoder stuck; the next poll's command clears it
    host.send_word(my_addr, 1'b0);
    step(WAIT + WORD);
    no_answer(my_addr, 1'b0, 1'b0, 0);
    full_xact(8'($urandom) & 8'h7f, 2, 0);
    $display("test late command done");
    final_report;
  end

  initial begin
    #(50 * 100000);
    timeout;
  end
endmodule
`default_nettype wire

// *** verilog/acd_buf2.sv ***
// Purpose: two-entry buffer with valid/ready on both sides
// Assumes: single clock
// Notes:   ready is registered from the next count, so it falls as the buffer fills
`timescale 1ns/1ps
`default_nettype none
module acd_buf2 #(
  parameter int unsigned W = 9
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  logic [W-1:0] mem [2];
  logic         wp;
  logic         rp;
  logic [1:0]   cnt;
  logic         push;
  logic         pop;
  logic [1:0]   next_cnt;

  always_comb begin
    push     = in_valid && in_ready;
    pop      = out_valid && out_ready;
    next_cnt = cnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt      <= '0;
      wp       <= 1'b0;
      rp       <= 1'b0;
      in_ready <= 1'b1;
    end else begin
      cnt      <= next_cnt;
      in_ready <= next_cnt != 2'd2;
      if (push) wp <= !wp;
      if (pop) rp <= !rp;
    end
  end

  always_ff @(posedge clk) begin
    if (push) mem[wp] <= in_data;
  end

  assign out_valid = cnt != 2'd0;
  assign out_data  = mem[rp];
endmodule
`default_nettype wire

// *** verilog/acd_decoder.sv ***
// Purpose: slave address/command decoder and response sequencer
// Assumes: rxd/local_addr synchronous; engine fills response bytes
// Notes:   transmitter drives the line only while line_oe is high
// Notes on behaviour
// - bad-parity words dropped, decoder restarts unless in D_STALE or D_RESP; D_STALE is left only on a good command
// - top data bit marks address words
// - only C0..FD are station addresses
// - FE and FF never match
// - matching address wakes, expects command; in D_STALE it is ignored and the command after it draws no answer
// - commands span 00..7F
// - transmitted bytes keep top bit zero, except the address echo
// - good command latched into buffer
// - bad command dropped, old kept
// - late command ignored, old kept
// - echo address then command first
// - echo returns decoder to idle
// - measure after echo, then send result
// - response framed by STX and ETX
// - colon separates multiple fields
// - only one station drives the line
// - words timed at 4800 baud
// - after response release driver, sleep
`timescale 1ns/1ps
`default_nettype none
module acd_decoder #(
  parameter int unsigned BIT_CYC      = acd_pkg::BIT_CYC,
  parameter int unsigned CMD_WAIT_CYC = acd_pkg::CMD_WAIT_CYC
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       rxd,
  output logic            txd,
  output logic            line_oe,
  input  wire logic [7:0] local_addr,
  output logic            wake,
  output logic [7:0]      cmd_buf,
  output logic            meas_start,
  input  wire logic       res_valid,
  output logic            res_ready,
  input  wire logic [6:0] res_char,
  input  wire logic       res_field_end,
  input  wire logic       res_last
);
  acd_pkg::acd_dec_t  dec;
  acd_pkg::acd_resp_t rsp;

  logic        word_valid;
  logic [7:0]  word_data;
  logic        word_ok;
  logic        is_addr;
  logic        addr_hit;
  logic        good_word;
  logic [acd_pkg::CNT_W-1:0] gap_cnt;
  logic        gap_over;

  logic        tx_busy;
  logic        tx_load;
  logic [7:0]  tx_byte;
  logic [10:0] tx_sh;
  logic [3:0]  tx_bits;
  logic [acd_pkg::CNT_W-1:0] tx_cnt;

  logic        b_valid;
  logic        b_ready;
  logic [acd_pkg::BUF_W-1:0] b_data;
  logic        buf_in_ready;
  logic        last_seen;

  acd_word_rx #(
    .CLKS_PER_BIT (BIT_CYC)
  ) u_rx (
    .clk        (clk),
    .rst_n      (rst_n),
    .rxd        (rxd),
    .word_valid (word_valid),
    .word_data  (word_data),
    .word_ok    (word_ok)
  );

  // stall by the sequencer back-pressures the measurement engine
  acd_buf2 #(
    .W (acd_pkg::BUF_W)
  ) u_buf (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (res_valid),
    .in_ready  (buf_in_ready),
    .in_data   ({res_last, res_field_end, res_char}),
    .out_valid (b_valid),
    .out_ready (b_ready),
    .out_data  (b_data)
  );
  assign res_ready = buf_in_ready;

  always_comb begin
    good_word = word_valid && word_ok;
    is_addr   = word_data[acd_pkg::ADDR_FLAG];
    addr_hit  = is_addr && word_data == local_addr &&
                local_addr >= acd_pkg::ADDR_MIN &&
                local_addr <= acd_pkg::ADDR_MAX;
    gap_over  = gap_cnt == acd_pkg::CNT_W'(CMD_WAIT_CYC);
  end

  // decoder state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dec <= acd_pkg::D_IDLE;
    end else begin
      case (dec)
        acd_pkg::D_IDLE: begin
          if (good_word && addr_hit) dec <= acd_pkg::D_WAIT;
        end
        acd_pkg::D_WAIT: begin
          if (word_valid && !word_ok) begin
            dec <= acd_pkg::D_IDLE;
          end else if (gap_over) begin
            // late command, decoder left half way
            dec <= acd_pkg::D_STALE;
          end else if (good_word && !is_addr) begin
            dec <= acd_pkg::D_RESP;
          end else if (good_word && !addr_hit) begin
            dec <= acd_pkg::D_IDLE;
          end
        end
        acd_pkg::D_STALE: begin
          // any good command word clears it, the late one included
          if (good_word && !is_addr) dec <= acd_pkg::D_IDLE;
        end
        acd_pkg::D_RESP: begin
          if (rsp == acd_pkg::R_MEAS) dec <= acd_pkg::D_IDLE;
        end
        default: dec <= acd_pkg::D_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_cnt <= '0;
    end else if (dec == acd_pkg::D_WAIT && !gap_over) begin
      gap_cnt <= gap_cnt + acd_pkg::CNT_W'(1);
    end else if (dec != acd_pkg::D_WAIT) begin
      gap_cnt <= '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_buf <= acd_pkg::CMD_RESET;
    end else if (dec == acd_pkg::D_WAIT && good_word && !is_addr &&
                 !gap_over) begin
      cmd_buf <= word_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wake <= 1'b0;
    end else if (dec == acd_pkg::D_IDLE && good_word && addr_hit) begin
      wake <= 1'b1;
    end else if (dec == acd_pkg::D_WAIT && word_valid && !word_ok) begin
      wake <= 1'b0;
    end else if (rsp == acd_pkg::R_END && !tx_busy) begin
      wake <= 1'b0;
    end
  end

  // response sequencer: load a byte only when the shifter is free
  always_comb begin
    tx_load = 1'b0;
    tx_byte = acd_pkg::CHAR_ETX;
    b_ready = 1'b0;
    if (!tx_busy) begin
      case (rsp)
        acd_pkg::R_ECHO_A: begin
          tx_load = 1'b1;
          tx_byte = local_addr;
        end
        acd_pkg::R_ECHO_C: begin
          tx_load = 1'b1;
          tx_byte = cmd_buf;
        end
        acd_pkg::R_STX: begin
          tx_load = 1'b1;
          tx_byte = acd_pkg::CHAR_STX;
        end
        acd_pkg::R_STREAM: begin
          tx_load = b_valid;
          b_ready = b_valid;
          tx_byte = {1'b0, b_data[6:0]};
        end
        acd_pkg::R_COLON: begin
          tx_load = 1'b1;
          // ETX takes the colon slot after the last byte
          tx_byte = last_seen ? acd_pkg::CHAR_ETX : acd_pkg::CHAR_COLON;
        end
        acd_pkg::R_END: begin
          tx_load = 1'b0;
          tx_byte = acd_pkg::CHAR_ETX;
        end
        default: begin
          tx_load = 1'b0;
          tx_byte = acd_pkg::CHAR_ETX;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp <= acd_pkg::R_IDLE;
    end else begin
      case (rsp)
        acd_pkg::R_IDLE:
          if (dec == acd_pkg::D_RESP) rsp <= acd_pkg::R_ECHO_A;
        acd_pkg::R_ECHO_A:
          if (tx_load) rsp <= acd_pkg::R_ECHO_C;
        acd_pkg::R_ECHO_C:
          if (tx_load) rsp <= acd_pkg::R_MEAS;
        acd_pkg::R_MEAS:
          if (!tx_busy) rsp <= acd_pkg::R_STX;
        acd_pkg::R_STX:
          if (tx_load) rsp <= acd_pkg::R_STREAM;
        acd_pkg::R_STREAM: begin
          if (tx_load && b_data[8]) rsp <= acd_pkg::R_COLON;
          else if (tx_load && b_data[7]) rsp <= acd_pkg::R_COLON;
        end
        acd_pkg::R_COLON:
          if (tx_load) rsp <= last_seen ? acd_pkg::R_END : acd_pkg::R_STREAM;
        acd_pkg::R_END:
          if (!tx_busy) rsp <= acd_pkg::R_IDLE;
        default: rsp <= acd_pkg::R_IDLE;
      endcase
    end
  end

  // colon state doubles as ETX state after the last byte
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      last_seen <= 1'b0;
    end else if (rsp == acd_pkg::R_STREAM && tx_load) begin
      last_seen <= b_data[8];
    end else if (rsp == acd_pkg::R_IDLE) begin
      last_seen <= 1'b0;
    end
  end

  // meas_start pulses once the echo has left the line
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meas_start <= 1'b0;
    end else begin
      meas_start <= rsp == acd_pkg::R_MEAS && !tx_busy;
    end
  end

  // transmit shifter, LSB first, even parity
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_busy <= 1'b0;
      tx_sh   <= '1;
      tx_bits <= '0;
      tx_cnt  <= '0;
    end else if (tx_load) begin
      tx_busy <= 1'b1;
      tx_sh   <= {1'b1, ^tx_byte, tx_byte, 1'b0};
      tx_bits <= 4'(acd_pkg::WORD_BITS - 1);
      tx_cnt  <= acd_pkg::CNT_W'(BIT_CYC - 1);
    end else if (tx_busy) begin
      if (tx_cnt != 0) begin
        tx_cnt <= tx_cnt - acd_pkg::CNT_W'(1);
      end else if (tx_bits == 0) begin
        tx_busy <= 1'b0;
      end else begin
        tx_cnt  <= acd_pkg::CNT_W'(BIT_CYC - 1);
        tx_bits <= tx_bits - 4'd1;
        tx_sh   <= {1'b1, tx_sh[10:1]};
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      line_oe <= 1'b0;
      txd     <= 1'b1;
    end else begin
      line_oe <= rsp != acd_pkg::R_IDLE &&
                 !(rsp == acd_pkg::R_END && !tx_busy);
      txd     <= tx_busy ? tx_sh[0] : 1'b1;
    end
  end

  // ETX sent from colon state when the last byte went out
  logic etx_go;
  assign etx_go = rsp == acd_pkg::R_COLON && !tx_busy && last_seen;

  // assertions
  // bad word keeps command
  property p_bad_keep;
    @(posedge clk) disable iff (!rst_n)
      word_valid && !word_ok |=> $stable(cmd_buf);
  endproperty
  a_bad_keep: assert property (p_bad_keep) else $error("bad word changed cmd");
  property p_wake;
    @(posedge clk) disable iff (!rst_n)
      dec == acd_pkg::D_IDLE && good_word && addr_hit
      |=> wake && dec == acd_pkg::D_WAIT;
  endproperty
  a_wake: assert property (p_wake) else $error("match did not wake");
  property p_resv;
    @(posedge clk) disable iff (!rst_n)
      dec == acd_pkg::D_IDLE && good_word &&
      (word_data < acd_pkg::ADDR_MIN || word_data > acd_pkg::ADDR_MAX)
      |=> dec == acd_pkg::D_IDLE;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved addr armed");
  property p_latch;
    @(posedge clk) disable iff (!rst_n)
      dec == acd_pkg::D_WAIT && good_word && !is_addr && !gap_over
      |=> cmd_buf == $past(word_data) ##1 rsp == acd_pkg::R_ECHO_A;
  endproperty
  a_latch: assert property (p_latch) else $error("command not latched");
  property p_late;
    @(posedge clk) disable iff (!rst_n)
      dec == acd_pkg::D_WAIT && gap_over && !word_valid
      |=> dec == acd_pkg::D_STALE && $stable(cmd_buf);
  endproperty
  a_late: assert property (p_late) else $error("late command taken");
  property p_seven;
    @(posedge clk) disable iff (!rst_n)
      tx_load && rsp == acd_pkg::R_STREAM |-> !tx_byte[7];
  endproperty
  a_seven: assert property (p_seven) else $error("data bit 7 set");
  // a word time is too long for a delay range, so count it here
  localparam int unsigned ECHO_LIM = BIT_CYC * acd_pkg::WORD_BITS + 1;
  logic [acd_pkg::CNT_W-1:0] echo_wait;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      echo_wait <= '0;
    end else if (rsp == acd_pkg::R_ECHO_C) begin
      echo_wait <= echo_wait + acd_pkg::CNT_W'(1);
    end else begin
      echo_wait <= '0;
    end
  end
  sequence s_echo;
    rsp == acd_pkg::R_ECHO_A && tx_load && tx_byte == local_addr;
  endsequence
  sequence s_echo_cmd;
    rsp == acd_pkg::R_ECHO_C && tx_load;
  endsequence
  property p_echo;
    @(posedge clk) disable iff (!rst_n)
      s_echo |=> rsp == acd_pkg::R_ECHO_C && echo_wait == '0;
  endproperty
  property p_echo_cmd;
    @(posedge clk) disable iff (!rst_n)
      s_echo_cmd |-> tx_byte == cmd_buf &&
                     echo_wait <= acd_pkg::CNT_W'(ECHO_LIM);
  endproperty
  a_echo_cmd: assert property (p_echo_cmd)
    else $error("command echo late");
  a_echo: assert property (p_echo) else $error("echo order wrong");
  property p_release;
    @(posedge clk) disable iff (!rst_n)
      rsp == acd_pkg::R_END && !tx_busy |=> ##1 !line_oe && !wake;
  endproperty
  a_release: assert property (p_release) else $error("driver held");
  property p_stray;
    @(posedge clk) disable iff (!rst_n)
      dec == acd_pkg::D_IDLE && good_word && !is_addr
      |=> dec == acd_pkg::D_IDLE && !line_oe;
  endproperty
  a_stray: assert property (p_stray) else $error("stray command seen");
  property p_etx;
    @(posedge clk) disable iff (!rst_n)
      etx_go |=> tx_sh[8:1] == acd_pkg::CHAR_ETX;
  endproperty
  a_etx: assert property (p_etx) else $error("ETX missing");
endmodule
`default_nettype wire

// *** verilog/acd_pkg.sv ***
// Purpose: shared constants for the addressed command decoder
// Assumes: 20 MHz system clock, 4800 baud 11-bit words
// Notes:   times kept in their own units, counts derived
package acd_pkg;
  localparam int unsigned CLK_HZ      = 20_000_000;
  localparam int unsigned BAUD        = 4800;
  // nearest whole cycle per bit, 4167 at these rates
  localparam int unsigned BIT_CYC     = (CLK_HZ + BAUD / 2) / BAUD;
  localparam int unsigned WORD_BITS   = 11;
  localparam int unsigned WORD_CYC    = BIT_CYC * WORD_BITS;
  // longest address-to-command gap, rounded down
  localparam int unsigned CMD_GAP_US  = 5000;
  localparam int unsigned CMD_GAP_CYC = CMD_GAP_US * (CLK_HZ / 1_000_000);
  localparam int unsigned CMD_WAIT_CYC = CMD_GAP_CYC + WORD_CYC;
  localparam int unsigned CNT_W       = 20;
  localparam logic [7:0]  ADDR_MIN    = 8'hc0;
  localparam logic [7:0]  ADDR_MAX    = 8'hfd;
  localparam int unsigned ADDR_FLAG   = 7;
  localparam logic [7:0]  CHAR_STX    = 8'h02;
  localparam logic [7:0]  CHAR_ETX    = 8'h03;
  localparam logic [7:0]  CHAR_COLON  = 8'h3a;
  localparam logic [7:0]  CMD_RESET   = 8'h00;
  localparam int unsigned BUF_W       = 9;

  typedef enum logic [1:0] {
    D_IDLE = 2'b00,
    D_WAIT = 2'b01,
    D_STALE = 2'b10,
    D_RESP = 2'b11
  } acd_dec_t;

  typedef enum logic [2:0] {
    R_IDLE   = 3'b000,
    R_ECHO_A = 3'b001,
    R_ECHO_C = 3'b010,
    R_MEAS   = 3'b011,
    R_STX    = 3'b100,
    R_STREAM = 3'b101,
    R_COLON  = 3'b110,
    R_END    = 3'b111
  } acd_resp_t;
endpackage

// *** verilog/acd_word_rx.sv ***
// Purpose: receive one 11-bit word, start, 8 data, even parity, stop
// Assumes: rxd synchronous to clk, idle high
// Notes:   framing error is reported as a bad word
`timescale 1ns/1ps
`default_nettype none
module acd_word_rx #(
  parameter int unsigned CLKS_PER_BIT = 4167
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       rxd,
  output logic            word_valid,
  output logic [7:0]      word_data,
  output logic            word_ok
);
  logic [19:0] cnt;
  logic [3:0]  bitn;
  logic        busy;
  logic [9:0]  sh;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy       <= 1'b0;
      cnt        <= '0;
      bitn       <= '0;
      sh         <= '0;
      word_valid <= 1'b0;
      word_data  <= '0;
      word_ok    <= 1'b0;
    end else begin
      word_valid <= 1'b0;
      if (!busy) begin
        if (!rxd) begin
          busy <= 1'b1;
          // first sample lands mid start bit
          cnt  <= 20'(CLKS_PER_BIT / 2);
          bitn <= '0;
        end
      end else if (cnt != 0) begin
        cnt <= cnt - 20'd1;
      end else begin
        cnt <= 20'(CLKS_PER_BIT - 1);
        if (bitn == 4'd0 && rxd) begin
          busy <= 1'b0;
        end else if (bitn == 4'd10) begin
          busy       <= 1'b0;
          word_valid <= 1'b1;
          word_data  <= sh[8:1];
          word_ok    <= rxd && !(^sh[9:1]);
        end else begin
          sh   <= {rxd, sh[9:1]};
          bitn <= bitn + 4'd1;
        end
      end
    end
  end
endmodule
`default_nettype wire
